/* File: design/dac_ctrl_consts.vh */
// Constants for the converter control block with non-volatile store
// Notes on behaviour
// - Any reset copies stored word into converter
// - Power-on and general-call reset both reload
// - Store holds two select plus twelve code
// - Host may access registers after power-on
// - Select 00 normal; 01/10/11 pick loads
// - Power-down stops conversion, bus stays alive
// - Normal-mode write or wake-up ends power-down
// - Select bits live in register and store
// - Command 011 starts a store write
// - Done flag low throughout store write
// - Register writes ignored while done flag low; general-call reset and wake-up still act
// - Code is unsigned, output code/4096 span
// - Command 00x updates register, not store
// - Commands with top bit set ignored
// - Delivered store: select 00, mid-scale code
// - Done flag returned in read status byte
`ifndef DAC_CTRL_CONSTS_VH
`define DAC_CTRL_CONSTS_VH

`define CLK_PERIOD_NS 20
`define NVM_WRITE_TIME_NS 25000000
// Store write time in clocks, 25 ms at a 20 ns clock
`define NVM_WRITE_CYCLES 24'h1312D0
`define CODE_W 12
`define PD_W 2
`define NVM_W 14
`define NVM_DEFAULT 14'h0800
`define DEV_CODE 4'hC
`define GC_ADDR 8'h00
`define GC_RESET 8'h06
`define GC_WAKEUP 8'h09
`define CMD_NVM 3'h3
`define PD_NORMAL 2'h0
`define PD_LOAD_1K 2'h1
`define PD_LOAD_100K 2'h2
`define PD_LOAD_500K 2'h3
`define READ_BYTES 3'h5

`endif

/* File: design/dac_nvm_powerdown_control.v */
// Converter register, non-volatile store and power-down control behind a serial slave
`include "dac_ctrl_consts.vh"

module dac_nvm_powerdown_control #(
  parameter [1:0] ADDR_HI_BITS = 2'h0,
  parameter [23:0] WRITE_CYCLES = `NVM_WRITE_CYCLES
) (
  input wire i_clk,
  input wire i_rstn,
  input wire i_scl,
  input wire i_sda,
  input wire i_a0,
  output wire o_sda,
  output reg o_sda_oe_n,
  output wire [`CODE_W-1:0] o_analog_out_code,
  output wire o_pwrdn_sel_hi,
  output wire o_pwrdn_sel_lo,
  output wire o_conv_enable,
  output wire o_load_1k,
  output wire o_load_100k,
  output wire o_load_500k,
  output wire o_nvm_write_done,
  output wire o_por_done
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RX = 3'h1;
  localparam [2:0] ST_ACK1 = 3'h2;
  localparam [2:0] ST_ACK2 = 3'h3;
  localparam [2:0] ST_TX = 3'h4;
  localparam [2:0] ST_TXACK = 3'h5;
  localparam [2:0] ST_TXGO = 3'h6;

  localparam [1:0] PH_ADDR = 2'h0;
  localparam [1:0] PH_GC = 2'h1;
  localparam [1:0] PH_DATA = 2'h2;

  wire [2:0] pins_sync;
  wire scl_s;
  wire sda_s;
  wire a0_s;
  reg scl_q;
  reg sda_q;

  reg [2:0] state_reg;
  reg [1:0] phase_reg;
  reg [2:0] bitcnt_reg;
  reg [7:0] shift_reg;
  reg [2:0] idx_reg;
  reg is_read_reg;
  reg ack_reg;
  reg [7:0] cmd_reg;
  reg [7:0] data_hi_reg;

  reg [`CODE_W-1:0] code_reg;
  reg [`PD_W-1:0] pd_reg;
  reg [`NVM_W-1:0] nvm_reg;
  reg [23:0] wtimer_reg;
  reg por_pend_reg;

  reg [7:0] rx_byte;
  reg [7:0] tx_byte;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire write_done;

  // Pins cross into the clock domain before anything reads them
  sync_2ff #(
    .W(3)
  ) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async({i_a0, i_sda, i_scl}),
    .o_sync(pins_sync)
  );

  assign scl_s = pins_sync[0];
  assign sda_s = pins_sync[1];
  assign a0_s = pins_sync[2];

  // Previous samples for edge detection
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_cond = scl_s & scl_q & ~sda_q & sda_s;
  assign write_done = (wtimer_reg == 24'h000000);

  // Byte just completed, including the bit on this rising edge
  always @* begin
    rx_byte = {shift_reg[6:0], sda_s};
  end

  // read data, status byte carries done flag
  always @* begin
    case (idx_reg)
      3'h0: tx_byte = {write_done, ~por_pend_reg, 3'h0, pd_reg, 1'b0};
      3'h1: tx_byte = code_reg[11:4];
      3'h2: tx_byte = {code_reg[3:0], 4'h0};
      3'h3: tx_byte = {1'b0, nvm_reg[13:12], 1'b0, nvm_reg[11:8]};
      3'h4: tx_byte = nvm_reg[7:0];
      default: tx_byte = 8'h00;
    endcase
  end

  // Serial engine, command decode and register/store updates
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_ADDR;
      bitcnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      idx_reg <= 3'h0;
      is_read_reg <= 1'b0;
      ack_reg <= 1'b0;
      cmd_reg <= 8'h00;
      data_hi_reg <= 8'h00;
      o_sda_oe_n <= 1'b1;
      code_reg <= 12'h000;
      pd_reg <= `PD_NORMAL;
      nvm_reg <= `NVM_DEFAULT;
      wtimer_reg <= 24'h000000;
      por_pend_reg <= 1'b1;
    end else begin
      // store write timer runs down alone
      if (!write_done) begin
        wtimer_reg <= wtimer_reg - 24'h000001;
      end
      // power-on copy of store into register
      if (por_pend_reg) begin
        pd_reg <= nvm_reg[13:12];
        code_reg <= nvm_reg[11:0];
        por_pend_reg <= 1'b0;
      end
      if (start_cond) begin
        // Repeated start restarts the address phase
        state_reg <= ST_RX;
        phase_reg <= PH_ADDR;
        bitcnt_reg <= 3'h0;
        o_sda_oe_n <= 1'b1;
      end else if (stop_cond) begin
        // Partial write groups are dropped at stop
        state_reg <= ST_IDLE;
        o_sda_oe_n <= 1'b1;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            o_sda_oe_n <= 1'b1;
          end
          ST_RX: begin
            if (scl_rise) begin
              shift_reg <= rx_byte;
              bitcnt_reg <= bitcnt_reg + 3'h1;
              if (bitcnt_reg == 3'h7) begin
                state_reg <= ST_ACK1;
                ack_reg <= 1'b1;
                case (phase_reg)
                  PH_ADDR: begin
                    idx_reg <= 3'h0;
                    if (rx_byte[7:1] == {`DEV_CODE, ADDR_HI_BITS, a0_s}) begin
                      is_read_reg <= rx_byte[0];
                      phase_reg <= PH_DATA;
                    end else if (rx_byte == `GC_ADDR) begin
                      is_read_reg <= 1'b0;
                      phase_reg <= PH_GC;
                    end else begin
                      // Not ours: stay off the line until next start
                      ack_reg <= 1'b0;
                      state_reg <= ST_IDLE;
                    end
                  end
                  PH_GC: begin
                    if (rx_byte == `GC_RESET) begin
                      pd_reg <= nvm_reg[13:12];
                      code_reg <= nvm_reg[11:0];
                    end
                    if (rx_byte == `GC_WAKEUP) begin
                      pd_reg <= `PD_NORMAL;
                    end
                  end
                  default: begin
                    case (idx_reg)
                      3'h0: begin
                        cmd_reg <= rx_byte;
                        idx_reg <= 3'h1;
                      end
                      3'h1: begin
                        idx_reg <= 3'h2;
                        data_hi_reg <= rx_byte;
                        if (cmd_reg[7:6] == 2'h0) begin
                          idx_reg <= 3'h0;
                          if (write_done) begin
                            pd_reg <= cmd_reg[5:4];
                            code_reg <= {cmd_reg[3:0], rx_byte};
                          end
                        end
                      end
                      default: begin
                        idx_reg <= 3'h0;
                        if (write_done && !cmd_reg[7]) begin
                          pd_reg <= cmd_reg[2:1];
                          code_reg <= {data_hi_reg, rx_byte[7:4]};
                          // command 011 writes the store too
                          if (cmd_reg[7:5] == `CMD_NVM) begin
                            nvm_reg <= {cmd_reg[2:1], data_hi_reg, rx_byte[7:4]};
                            wtimer_reg <= WRITE_CYCLES;
                          end
                        end
                      end
                    endcase
                  end
                endcase
              end
            end
          end
          ST_ACK1: begin
            // Acknowledge is driven from the falling edge
            if (scl_fall) begin
              o_sda_oe_n <= ~ack_reg;
              state_reg <= ST_ACK2;
            end
          end
          ST_ACK2: begin
            if (scl_fall) begin
              if (is_read_reg && phase_reg == PH_DATA) begin
                o_sda_oe_n <= tx_byte[7];
                shift_reg <= {tx_byte[6:0], 1'b0};
                bitcnt_reg <= 3'h1;
                idx_reg <= (idx_reg == `READ_BYTES - 3'h1) ? 3'h0 : idx_reg + 3'h1;
                state_reg <= ST_TX;
              end else begin
                o_sda_oe_n <= 1'b1;
                bitcnt_reg <= 3'h0;
                state_reg <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bitcnt_reg == 3'h0) begin
                o_sda_oe_n <= 1'b1;
                state_reg <= ST_TXACK;
              end else begin
                o_sda_oe_n <= shift_reg[7];
                shift_reg <= {shift_reg[6:0], 1'b0};
                bitcnt_reg <= bitcnt_reg + 3'h1;
              end
            end
          end
          ST_TXACK: begin
            // Master's not-acknowledge ends the read
            if (scl_rise) begin
              state_reg <= sda_s ? ST_IDLE : ST_TXGO;
            end
          end
          ST_TXGO: begin
            if (scl_fall) begin
              o_sda_oe_n <= tx_byte[7];
              shift_reg <= {tx_byte[6:0], 1'b0};
              bitcnt_reg <= 3'h1;
              idx_reg <= (idx_reg == `READ_BYTES - 3'h1) ? 3'h0 : idx_reg + 3'h1;
              state_reg <= ST_TX;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Open drain: only ever pulls low
  assign o_sda = 1'b0;

  // unsigned code straight to the converter
  assign o_analog_out_code = code_reg;
  assign o_pwrdn_sel_hi = pd_reg[1];
  assign o_pwrdn_sel_lo = pd_reg[0];
  // power-down stops conversion; serial engine unaffected
  assign o_conv_enable = (pd_reg == `PD_NORMAL) & ~por_pend_reg;
  assign o_load_1k = (pd_reg == `PD_LOAD_1K);
  assign o_load_100k = (pd_reg == `PD_LOAD_100K);
  assign o_load_500k = (pd_reg == `PD_LOAD_500K);
  assign o_nvm_write_done = write_done;
  // host access meaningful once load done
  assign o_por_done = ~por_pend_reg;
endmodule

/* File: design/sync_2ff.v */
// Two flip-flop synchroniser for inputs from outside the clock domain
module sync_2ff #(
  parameter W = 1
) (
  input wire i_clk,
  input wire i_rstn,
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // First stage feeds only the second stage
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_reg <= {W{1'b1}};
      sync_reg <= {W{1'b1}};
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule

/* File: tb/dac_ctrl_checker.sv */
// Port-level assertions for the converter control block
module dac_ctrl_checker #(
  parameter [23:0] WRITE_CYCLES = 24'd20
) (
  input wire i_clk,
  input wire i_rstn,
  input wire [11:0] o_analog_out_code,
  input wire o_pwrdn_sel_hi,
  input wire o_pwrdn_sel_lo,
  input wire o_conv_enable,
  input wire o_load_1k,
  input wire o_load_100k,
  input wire o_load_500k,
  input wire o_nvm_write_done,
  input wire o_por_done
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  wire [1:0] sel = {o_pwrdn_sel_hi, o_pwrdn_sel_lo};
  reg [23:0] busy_cnt_reg;
  // Busy length counter, cleared while idle
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      busy_cnt_reg <= 24'h0;
    else
      busy_cnt_reg <= o_nvm_write_done ? 24'h0 : busy_cnt_reg + 24'h1;
  end
  sequence s_wr_start;
    $fell(o_nvm_write_done);
  endsequence
  sequence s_busy;
    (!o_nvm_write_done) [*8];
  endsequence
  property p_l1k; o_load_1k == (sel == 2'h1); endproperty
  property p_l100k; o_load_100k == (sel == 2'h2); endproperty
  property p_l500k; o_load_500k == (sel == 2'h3); endproperty
  property p_conv; o_por_done |-> o_conv_enable == (sel == 2'h0); endproperty
  property p_por_load; $rose(o_por_done) |-> o_analog_out_code == 12'h800 && sel == 2'h0; endproperty
  property p_por_hold; o_por_done |=> o_por_done; endproperty
  property p_busy_min; s_wr_start |-> s_busy; endproperty
  property p_busy_max; !o_nvm_write_done |-> busy_cnt_reg < WRITE_CYCLES + 24'd2; endproperty
  property p_busy_len; $rose(o_nvm_write_done) |-> busy_cnt_reg == WRITE_CYCLES; endproperty
  // Held state frozen while the store is written
  property p_freeze;
    !o_nvm_write_done && !$past(o_nvm_write_done) |-> $stable(o_analog_out_code) && $stable(sel);
  endproperty
  a_l1k: assert property (p_l1k) else $error("1k load mismatch");
  a_l100k: assert property (p_l100k) else $error("100k load mismatch");
  a_l500k: assert property (p_l500k) else $error("500k load mismatch");
  a_conv: assert property (p_conv) else $error("conversion enable mismatch");
  a_por_load: assert property (p_por_load) else $error("power-on load wrong");
  a_por_hold: assert property (p_por_hold) else $error("power-on done dropped");
  a_busy_min: assert property (p_busy_min) else $error("store write too short");
  a_busy_max: assert property (p_busy_max) else $error("store write too long");
  a_busy_len: assert property (p_busy_len) else $error("store write length wrong");
  a_freeze: assert property (p_freeze) else $error("state changed while busy");
endmodule
bind dac_nvm_powerdown_control dac_ctrl_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (
  .i_clk(i_clk), .i_rstn(i_rstn), .o_analog_out_code(o_analog_out_code),
  .o_pwrdn_sel_hi(o_pwrdn_sel_hi), .o_pwrdn_sel_lo(o_pwrdn_sel_lo), .o_conv_enable(o_conv_enable),
  .o_load_1k(o_load_1k), .o_load_100k(o_load_100k), .o_load_500k(o_load_500k),
  .o_nvm_write_done(o_nvm_write_done), .o_por_done(o_por_done));

/* File: tb/i2c_host_model.sv */
// Serial bus host model, open-drain data, clock idle high between frames
module i2c_host_model (
  input wire i_clk,
  input wire i_sda,
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Quarter of a 160 ns bit, always 1 ns after a clock edge
  task automatic q;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  // Data moves mid-low so the synchronised sampler never races it
  task automatic bit_x(input logic b, output logic r);
    q;
    o_sda = b;
    q;
    o_scl = 1'b1;
    q;
    r = i_sda;
    q;
    o_scl = 1'b0;
  endtask
  task automatic start;
    q;
    o_sda = 1'b0;
    q;
    o_scl = 1'b0;
  endtask
  task automatic stop;
    q;
    o_sda = 1'b0;
    q;
    o_scl = 1'b1;
    q;
    o_sda = 1'b1;
    q;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench of the converter control block
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [23:0] WCYC = 24'd800;
  logic i_clk = 1'b0, i_rstn = 1'b0, a0 = 1'b1, ack;
  wire scl, sda_m, oe_n, sda_pin, conv, l1, l2, l3, done, por, sh, sl, dut_sda;
  wire [11:0] code;
  int n_fail = 0, num_checks = 0, e_code, e_sel, s_code, s_sel, e_done, v;
  logic [31:0] rs = 32'h465F;
  logic [7:0] d0, d1, d2, d3, d4;
  // Pull-up wins unless either side pulls low; device drives its own output value
  assign sda_pin = sda_m & (oe_n | dut_sda);
  dac_nvm_powerdown_control #(.ADDR_HI_BITS(2'h0), .WRITE_CYCLES(WCYC)) dut_u (.i_clk(i_clk),
    .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda_pin), .i_a0(a0), .o_sda(dut_sda), .o_sda_oe_n(oe_n),
    .o_analog_out_code(code), .o_pwrdn_sel_hi(sh), .o_pwrdn_sel_lo(sl), .o_conv_enable(conv),
    .o_load_1k(l1), .o_load_100k(l2), .o_load_500k(l3), .o_nvm_write_done(done), .o_por_done(por));
  i2c_host_model host_u (.i_clk(i_clk), .i_sda(sda_pin), .o_scl(scl), .o_sda(sda_m));
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task results;
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk;
    `CHK(code, e_code[11:0])
    `CHK({sh, sl}, e_sel[1:0])
    `CHK({conv, l1, l2, l3}, {e_sel == 0, e_sel == 1, e_sel == 2, e_sel == 3})
  endtask
  task wr(input logic [7:0] a, input int n, input logic [7:0] b0, b1, b2, input logic ea);
    host_u.start;
    host_u.put(a, ack);
    `CHK(ack, ea)
    if (ack) host_u.put(b0, ack);
    if (ack && n > 1) host_u.put(b1, ack);
    if (ack && n > 2) host_u.put(b2, ack);
    host_u.stop;
    repeat (8) @(posedge i_clk);
  endtask
  task fast(input int s, input int c);
    wr(8'hC2, 2, {2'b00, s[1:0], c[11:8]}, c[7:0], 8'h00, 1'b1);
  endtask
  task cmd3(input int t, input int s, input int c);
    wr(8'hC2, 3, {t[2:0], 2'b00, s[1:0], 1'b0}, c[11:4], {c[3:0], 4'h0}, 1'b1);
  endtask
  task rd;
    host_u.start;
    host_u.put(8'hC3, ack);
    `CHK(ack, 1'b1)
    host_u.get(1'b0, d0);
    host_u.get(1'b0, d1);
    host_u.get(1'b0, d2);
    host_u.get(1'b0, d3);
    host_u.get(1'b1, d4);
    host_u.stop;
    `CHK({d0, d1, d2}, {e_done[0], 1'b1, 3'b000, e_sel[1:0], 1'b0, e_code[11:0], 4'h0})
    `CHK({d3, d4}, {1'b0, s_sel[1:0], 1'b0, s_code[11:0]})
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #1ms;
    n_fail++;
    results;
  end
  initial begin
    e_code = 'h800;
    e_sel = 0;
    e_done = 1;
    s_code = 'h800;
    s_sel = 0;
    repeat (4) @(posedge i_clk);
    #1 i_rstn = 1'b1;
    repeat (4) @(posedge i_clk);
    // Delivered store word after power-on
    chk;
    rd;
    // Every select with a random code
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      e_code = rs[11:0];
      e_sel = i;
      fast(e_sel, e_code);
      chk;
    end
    // Wake-up keeps the code
    wr(8'h00, 1, 8'h09, 8'h00, 8'h00, 1'b1);
    e_sel = 0;
    chk;
    for (int c = 4; c < 8; c++) begin
      rs = xs(rs);
      cmd3(c, rs[13:12], rs[11:0]);
      chk;
    end
    rs = xs(rs);
    e_code = rs[11:0];
    e_sel = 1;
    cmd3(2, e_sel, e_code);
    chk;
    // Store write; later writes refused until done
    rs = xs(rs);
    e_code = rs[11:0];
    e_sel = 2;
    s_code = e_code;
    s_sel = e_sel;
    cmd3(3, e_sel, e_code);
    e_done = 0;
    chk;
    fast(0, 'h123);
    chk;
    rd;
    for (v = 0; v < 2000 && done !== 1'b1; v++) @(posedge i_clk);
    e_done = 1;
    `CHK(done, 1'b1)
    // Writes take effect again once the store is done
    e_code = 'hABC;
    e_sel = 1;
    fast(e_sel, e_code);
    chk;
    wr(8'h00, 1, 8'h06, 8'h00, 8'h00, 1'b1);
    e_code = s_code;
    e_sel = s_sel;
    chk;
    // Other address bit is not ours
    wr(8'hC0, 1, 8'h00, 8'h00, 8'h00, 1'b0);
    chk;
    // Address pin low moves the device to the even address
    #1 a0 = 1'b0;
    rs = xs(rs);
    e_code = rs[11:0];
    e_sel = 0;
    wr(8'hC0, 2, {4'h0, e_code[11:8]}, e_code[7:0], 8'h00, 1'b1);
    chk;
    #1 a0 = 1'b1;
    rd;
    results;
  end
endmodule
